/* bench/encoder_pin_model.sv */
// Quadrature and latch pin source standing in for the field encoders.
// Assumes one-cycle step pulses from the bench, spaced wider than the pin filter.
`timescale 1ns/100ps
module encoder_pin_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic stepGo,
  input wire logic stepCh,
  input wire logic stepUp,
  input wire logic latchIn,
  output logic [4:0] encPins
);
  logic [1:0] phase0Reg;
  logic [1:0] phase1Reg;
  // ----------------------------------------------------------------
  // Phase walk
  // ----------------------------------------------------------------
  // Gray walk, one quarter cycle per step, A leads B going up
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase0Reg <= 2'h0;
      phase1Reg <= 2'h0;
    end else if (stepGo && !stepCh) begin
      phase0Reg <= stepUp ? phase0Reg + 2'h1 : phase0Reg - 2'h1;
    end else if (stepGo) begin
      phase1Reg <= stepUp ? phase1Reg + 2'h1 : phase1Reg - 2'h1;
    end
  end
  // Pin order: latch, B2, A2, B1, A1
  assign encPins = {latchIn, phase1Reg[1], ^phase1Reg, phase0Reg[1], ^phase0Reg};
endmodule

/* bench/tb_top.sv */
// Self-checking bench: all three variants share one image port and one pin source.
// Assumes the image master never waits and rdata stands one cycle after rdEn.
`timescale 1ns/100ps
module tb_top
  import encoder_image_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic stepGo = 1'b0;
  logic stepCh = 1'b0;
  logic stepUp = 1'b0;
  logic latchIn = 1'b0;
  logic ce = 1'b1;
  logic [4:0] encPins;
  logic [15:0] rdata [3];
  int numErrors = 0;
  int checksDone = 0;
  int cycles = 0;
  // ----------------------------------------------------------------
  // Clock, devices and pin source
  // ----------------------------------------------------------------
  always #50 mclk = ~mclk;
  // One instance per variant, index equals VARIANT
  for (genvar gv = 0; gv < 3; gv++) begin : g_var
    encoder_process_image_map #(.VARIANT(2'(gv))) uut (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .encPins(encPins),
      .addr(addr),
      .wdata(wdata),
      .wrEn(wrEn),
      .rdEn(rdEn),
      .rdata(rdata[gv])
    );
  end
  encoder_pin_model pins (
    .mclk(mclk),
    .rstn(rstn),
    .stepGo(stepGo),
    .stepCh(stepCh),
    .stepUp(stepUp),
    .latchIn(latchIn),
    .encPins(encPins)
  );
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      numErrors++;
      give_verdict();
    end
  end
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [1:0] a, logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wrEn <= 1'b1;
    @(posedge mclk);
    wrEn <= 1'b0;
  endtask
  // Mask m picks which variants are judged; data must drop back to zero after
  task automatic rd(logic [1:0] a, logic [2:0] m, logic [15:0] e0, e1, e2);
    logic [15:0] e [3];
    e = '{e0, e1, e2};
    @(posedge mclk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge mclk);
    rdEn <= 1'b0;
    @(negedge mclk);
    for (int i = 0; i < 3; i++) if (m[i]) chk(rdata[i], e[i]);
    @(negedge mclk);
    for (int i = 0; i < 3; i++) if (m[i]) chk(rdata[i], 16'h0000);
  endtask
  // Steps eight cycles apart, so a full quadrature cycle lasts 32 cycles
  task automatic step(logic ch, logic up, int n);
    repeat (n) begin
      @(posedge mclk);
      stepCh <= ch;
      stepUp <= up;
      stepGo <= 1'b1;
      @(posedge mclk);
      stepGo <= 1'b0;
      repeat (6) @(posedge mclk);
    end
    repeat (10) @(posedge mclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int w = 0; w < 4; w++) rd(2'(w), 3'h7, 16'h0000, 16'h0000, 16'h0000);
    $display("test reset image done");
  endtask
  task automatic t_count();
    step(1'b0, 1'b1, 5);
    step(1'b0, 1'b0, 2);
    step(1'b1, 1'b1, 3);
    rd(2'h1, 3'h7, 16'h0003, 16'h0003, 16'h0003);
    rd(2'h2, 3'h7, 16'h0000, 16'h0000, 16'h0000);
    rd(2'h3, 3'h7, 16'h0000, 16'h0000, 16'h0003);
    $display("test counting done");
  endtask
  task automatic t_preset();
    wr(2'h1, 16'h1234);
    wr(2'h0, 16'hAB01);
    repeat (3) @(posedge mclk);
    rd(2'h1, 3'h7, 16'h1234, 16'h1234, 16'h1234);
    rd(2'h0, 3'h7, 16'h0001, 16'h0001, 16'h0001);
    wr(2'h0, 16'h0000);
    $display("test preset done");
  endtask
  // Words 2 and 3 are padding except on the two-channel variant
  task automatic t_unused();
    wr(2'h3, 16'hFFFF);
    wr(2'h2, 16'h00FF);
    repeat (3) @(posedge mclk);
    rd(2'h2, 3'h7, 16'h0000, 16'h0000, 16'h0001);
    rd(2'h3, 3'h7, 16'h0000, 16'h0000, 16'hFFFF);
    wr(2'h2, 16'h0000);
    $display("test unused words done");
  endtask
  task automatic t_latch();
    wr(2'h0, 16'h0002);
    @(posedge mclk);
    latchIn <= 1'b1;
    repeat (10) @(posedge mclk);
    latchIn <= 1'b0;
    repeat (10) @(posedge mclk);
    rd(2'h3, 3'h3, 16'h1234, 16'h1234, 16'h0000);
    rd(2'h0, 3'h3, 16'h0002, 16'h0002, 16'h0000);
    $display("test latch done");
  endtask
  // Period mode is honoured only by the cycle variant
  task automatic t_period();
    wr(2'h0, 16'h0004);
    step(1'b0, 1'b1, 12);
    rd(2'h0, 3'h3, 16'h0000, 16'h0004, 16'h0000);
    rd(2'h2, 3'h3, 16'h0000, 16'h0000, 16'h0000);
    rd(2'h3, 3'h3, 16'h1234, 16'h0020, 16'h0000);
    $display("test period done");
  endtask
  // Pins walk a full cycle while frozen, so a live filter would count four
  task automatic t_freeze();
    @(posedge mclk);
    ce <= 1'b0;
    step(1'b0, 1'b1, 4);
    ce <= 1'b1;
    rd(2'h1, 3'h7, 16'h1240, 16'h1240, 16'h1240);
    $display("test clock enable done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_count();
    t_preset();
    t_unused();
    t_latch();
    t_period();
    t_freeze();
    give_verdict();
  end
endmodule

/* rtl/encoder_image_pkg.sv */
// Constants and carriers for the encoder process image block.
// Assumes a 16-bit word-indexed image port and a single 10 MHz clock.
package encoder_image_pkg;
  // ----------------------------------------------------------------
  // Variants
  // ----------------------------------------------------------------
  localparam logic [1:0] VAR_SINGLE = 2'h0;
  localparam logic [1:0] VAR_CYCLE = 2'h1;
  localparam logic [1:0] VAR_TWO_CH = 2'h2;
  // ----------------------------------------------------------------
  // Image sizes
  // ----------------------------------------------------------------
  localparam int IMAGE_WORDS = 4;
  localparam int SINGLE_IN_BYTES = 5;
  localparam int SINGLE_OUT_BYTES = 3;
  localparam int CYCLE_IN_BYTES = 6;
  localparam int TWO_CH_BYTES = 6;
  localparam int CLK_PERIOD_NS = 100;
  // ----------------------------------------------------------------
  // Word offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] WORD_CTL_STAT0 = 2'h0;
  localparam logic [1:0] WORD_DATA0 = 2'h1;
  localparam logic [1:0] WORD_SPARE2 = 2'h2;
  localparam logic [1:0] WORD_DATA3 = 2'h3;
  // ----------------------------------------------------------------
  // Pin positions and field widths
  // ----------------------------------------------------------------
  localparam int PIN_A0 = 0;
  localparam int PIN_B0 = 1;
  localparam int PIN_A1 = 2;
  localparam int PIN_B1 = 3;
  localparam int PIN_LATCH = 4;
  localparam int PIN_COUNT = 5;
  localparam int PERIOD_BITS = 24;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [23:0] PERIOD_MAX = 24'hFFFFFF;
  localparam logic [1:0] STEP_NONE = 2'h0;
  localparam logic [1:0] STEP_UP = 2'h1;
  localparam logic [1:0] STEP_DOWN = 2'h3;
  // ----------------------------------------------------------------
  // Control and status bytes
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] spare;
    logic periodMode;
    logic latchEn;
    logic presetLoad;
  } ctl_s;
  typedef struct packed {
    logic [4:0] spare;
    logic periodOn;
    logic latched;
    logic presetAck;
  } stat_s;
  localparam ctl_s CTL_RESET = '{spare: 5'h00, periodMode: 1'b0, latchEn: 1'b0,
                                 presetLoad: 1'b0};
endpackage

/* rtl/encoder_process_image_map.sv */
// Encoder interface logic behind a word-aligned input/output process image.
// Assumes pins are asynchronous to mclk and the image master never waits.
`timescale 1ns/100ps
// What this block does
// - Single-counter variant: five input bytes, three output bytes of user data.
// - Single-counter variant takes four words per image, rest padding.
// - Multi-byte items sit on word boundaries; alignment bytes stay unused.
// - Input: status word 0 low, counter word 1, word 2 unused, latch word 3.
// - Output: control word 0 low, preset word 1; words 2 and 3 unused.
// - Cycle variant keeps four words, single layout while period mode is off.
// - Period mode uses six input bytes; output stays three bytes.
// - Period is 24 bits: extension byte in word 2 low, word 3.
// - Two-channel variant: six bytes each image, four data, two ctl/status.
// - Two-channel variant takes four words per image.
// - Channel 1: ctl/status in word 0 low, data in word 1.
// - Channel 2: ctl/status in word 2 low, data in word 3.
module encoder_process_image_map
  import encoder_image_pkg::*;
#(
  parameter logic [1:0] VARIANT = VAR_SINGLE
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [PIN_COUNT-1:0] encPins,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [15:0] rdata
);
  localparam bit TWO_CH = (VARIANT == VAR_TWO_CH);
  localparam bit CYCLE = (VARIANT == VAR_CYCLE);
  localparam int IN_BYTES = TWO_CH ? TWO_CH_BYTES : SINGLE_IN_BYTES;
  localparam int OUT_BYTES = TWO_CH ? TWO_CH_BYTES : SINGLE_OUT_BYTES;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Quadrature step from previous and present A/B levels
  function automatic logic [1:0] quadStep(input logic pa, input logic pb,
                                          input logic a, input logic b);
    logic [1:0] res;
    res = STEP_NONE;
    if ((pa != a) && (pb == b)) begin
      res = (a != b) ? STEP_UP : STEP_DOWN;
    end else if ((pb != b) && (pa == a)) begin
      res = (a == b) ? STEP_UP : STEP_DOWN;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] syncA_reg;
  logic [PIN_COUNT-1:0] syncB_reg;
  logic [PIN_COUNT-1:0] syncC_reg;
  logic [PIN_COUNT-1:0] pinFilt_reg;
  logic [PIN_COUNT-1:0] pinPrev_reg;

  // Three stages; a level is taken only once stages two and three agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      syncC_reg <= '0;
      pinFilt_reg <= '0;
      pinPrev_reg <= '0;
    end else if (ce) begin
      syncA_reg <= encPins;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (syncB_reg[i] == syncC_reg[i]) begin
          pinFilt_reg[i] <= syncC_reg[i];
        end
      end
      pinPrev_reg <= pinFilt_reg;
    end
  end

  wire logic latchRise = pinFilt_reg[PIN_LATCH] & ~pinPrev_reg[PIN_LATCH];
  wire logic a0Rise = pinFilt_reg[PIN_A0] & ~pinPrev_reg[PIN_A0];

  // ----------------------------------------------------------------
  // Output image: control bytes and preset words
  // ----------------------------------------------------------------
  ctl_s ctl_reg [2];
  logic [15:0] preset_reg [2];

  // Only documented positions are stored; the rest of the image is dropped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl_reg[0] <= CTL_RESET;
      ctl_reg[1] <= CTL_RESET;
      preset_reg[0] <= WORD_RESET;
      preset_reg[1] <= WORD_RESET;
    end else if (ce && wrEn) begin
      if (addr == WORD_CTL_STAT0) begin
        ctl_reg[0] <= '{spare: 5'h00, periodMode: wdata[2] & CYCLE,
                        latchEn: wdata[1], presetLoad: wdata[0]};
      end else if (addr == WORD_DATA0) begin
        preset_reg[0] <= wdata;
      end else if (addr == WORD_SPARE2 && TWO_CH) begin
        ctl_reg[1] <= '{spare: 5'h00, periodMode: 1'b0,
                        latchEn: wdata[1], presetLoad: wdata[0]};
      end else if (addr == WORD_DATA3 && TWO_CH) begin
        preset_reg[1] <= wdata;
      end
      // Other positions ignored
    end
  end

  // ----------------------------------------------------------------
  // Counters with preset on the rising edge of the load bit
  // ----------------------------------------------------------------
  logic [15:0] count_reg [2];
  logic [1:0] presetSeen_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_reg[0] <= WORD_RESET;
      count_reg[1] <= WORD_RESET;
      presetSeen_reg <= 2'h0;
    end else if (ce) begin
      for (int ch = 0; ch < 2; ch++) begin
        presetSeen_reg[ch] <= ctl_reg[ch].presetLoad;
        if (ctl_reg[ch].presetLoad && !presetSeen_reg[ch]) begin
          count_reg[ch] <= preset_reg[ch];
        end else begin
          case (quadStep(pinPrev_reg[2*ch], pinPrev_reg[2*ch+1],
                         pinFilt_reg[2*ch], pinFilt_reg[2*ch+1]))
            STEP_UP: count_reg[ch] <= count_reg[ch] + 16'h0001;
            STEP_DOWN: count_reg[ch] <= count_reg[ch] - 16'h0001;
            default: count_reg[ch] <= count_reg[ch];
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Latch of channel 1 on the reference pin
  // ----------------------------------------------------------------
  logic [15:0] latch_reg;
  logic latched_reg;

  // Flag clears with latch enable low, and a reference rise captures only while enabled
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      latch_reg <= WORD_RESET;
      latched_reg <= 1'b0;
    end else if (ce) begin
      if (ctl_reg[0].latchEn && latchRise) begin
        latch_reg <= count_reg[0];
        latched_reg <= 1'b1;
      end else if (!ctl_reg[0].latchEn) begin
        latched_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Period measurement between rising A edges of channel 1
  // ----------------------------------------------------------------
  logic [PERIOD_BITS-1:0] periodCnt_reg;
  logic [PERIOD_BITS-1:0] period_reg;
  wire logic periodOn = CYCLE && ctl_reg[0].periodMode;

  // Saturates rather than wraps, so a period beyond the counter range reads as maximum at the next rise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      periodCnt_reg <= '0;
      period_reg <= '0;
    end else if (ce) begin
      if (!periodOn) begin
        periodCnt_reg <= '0;
      end else if (a0Rise) begin
        period_reg <= periodCnt_reg;
        periodCnt_reg <= 24'h000001;
      end else if (periodCnt_reg != PERIOD_MAX) begin
        periodCnt_reg <= periodCnt_reg + 24'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input image read-back
  // ----------------------------------------------------------------
  stat_s stat0;
  stat_s stat1;
  assign stat0 = '{spare: 5'h00, periodOn: periodOn, latched: latched_reg,
                   presetAck: presetSeen_reg[0]};
  assign stat1 = '{spare: 5'h00, periodOn: 1'b0, latched: 1'b0,
                   presetAck: presetSeen_reg[1]};

  logic [15:0] rdata_next;

  // High bytes of the control/status words are alignment padding
  always_comb begin
    rdata_next = WORD_RESET;
    if (addr == WORD_CTL_STAT0) begin
      rdata_next = {BYTE_ZERO, stat0};
    end else if (addr == WORD_DATA0) begin
      rdata_next = count_reg[0];
    end else if (addr == WORD_SPARE2) begin
      if (TWO_CH) begin
        rdata_next = {BYTE_ZERO, stat1};
      end else if (periodOn) begin
        rdata_next = {BYTE_ZERO, period_reg[23:16]};
      end
    end else if (addr == WORD_DATA3) begin
      if (TWO_CH) begin
        rdata_next = count_reg[1];
      end else if (periodOn) begin
        rdata_next = period_reg[15:0];
      end else begin
        rdata_next = latch_reg;
      end
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= WORD_RESET;
    end else if (ce) begin
      rdata <= rdEn ? rdata_next : WORD_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Preset word must land whole, and the variant's bytes must fit four words
  property p_imageSize;
    @(posedge mclk) disable iff (!rstn || !ce)
      (wrEn && addr == WORD_DATA0) |=> (preset_reg[0] == $past(wdata))
        && (IN_BYTES <= 2 * IMAGE_WORDS) && (OUT_BYTES <= 2 * IMAGE_WORDS);
  endproperty
  a_imageSize: assert property (p_imageSize) else $error("preset word not stored");

  property p_statusPad;
    @(posedge mclk) disable iff (!rstn || !ce)
      (rdEn && addr == WORD_CTL_STAT0) |=> (rdata[15:8] == 8'h00 && rdata[7:5] == 3'h0);
  endproperty
  a_statusPad: assert property (p_statusPad) else $error("status word padding not zero");

  property p_countRead;
    @(posedge mclk) disable iff (!rstn || !ce)
      (rdEn && addr == WORD_DATA0) |=> (rdata == $past(count_reg[0]));
  endproperty
  a_countRead: assert property (p_countRead) else $error("counter word mismatch");

  property p_spareZero;
    @(posedge mclk) disable iff (!rstn || !ce)
      (rdEn && addr == WORD_SPARE2 && !TWO_CH && !periodOn) |=> (rdata == 16'h0000);
  endproperty
  a_spareZero: assert property (p_spareZero) else $error("unused word 2 not zero");

  property p_periodRead;
    @(posedge mclk) disable iff (!rstn || !ce)
      (rdEn && addr == WORD_DATA3 && periodOn && !TWO_CH)
        |=> (rdata == $past(period_reg[15:0]));
  endproperty
  a_periodRead: assert property (p_periodRead) else $error("period low word mismatch");

  property p_latchRead;
    @(posedge mclk) disable iff (!rstn || !ce)
      (rdEn && addr == WORD_DATA3 && !periodOn && !TWO_CH) |=> (rdata == $past(latch_reg));
  endproperty
  a_latchRead: assert property (p_latchRead) else $error("latch word mismatch");

  property p_presetLoad;
    @(posedge mclk) disable iff (!rstn || !ce)
      $rose(ctl_reg[0].presetLoad) |=> (count_reg[0] == $past(preset_reg[0]));
  endproperty
  a_presetLoad: assert property (p_presetLoad) else $error("preset not loaded");

  property p_ignoreUnused;
    @(posedge mclk) disable iff (!rstn || !ce)
      (wrEn && !TWO_CH && addr[1]) |=> ($stable(ctl_reg[1]) && $stable(preset_reg[1]));
  endproperty
  a_ignoreUnused: assert property (p_ignoreUnused) else $error("unused write stored");

  property p_readOnce;
    @(posedge mclk) disable iff (!rstn || !ce)
      !rdEn |=> (rdata == 16'h0000);
  endproperty
  a_readOnce: assert property (p_readOnce) else $error("read data held too long");

  // Period reporting follows the written control bit, cycle variant only
  property p_modeOff;
    @(posedge mclk) disable iff (!rstn || !ce)
      (wrEn && addr == WORD_CTL_STAT0) |=> (periodOn == (CYCLE && $past(wdata[2])));
  endproperty
  a_modeOff: assert property (p_modeOff) else $error("period mode not following control");

  property p_periodHigh;
    @(posedge mclk) disable iff (!rstn || !ce)
      (rdEn && addr == WORD_SPARE2 && periodOn && !TWO_CH)
        |=> (rdata == {8'h00, $past(period_reg[23:16])});
  endproperty
  a_periodHigh: assert property (p_periodHigh) else $error("period high byte mismatch");
endmodule
